/* rtl/touch_pkg.sv */
package touch_pkg;
	localparam int          NUM_CH        = 3;
	localparam int          CW            = 16;
	localparam int          BETA_SHIFT    = 8;
	localparam logic [15:0] CNT_RESET     = 16'h0000;
	localparam logic [7:0]  TIMEOUT_NEVER = 8'h00;
	localparam int          RES_SHIFT     = 4;
	localparam logic [3:0]  ADDR_SYS_CTRL = 4'h0;
	localparam logic [3:0]  ADDR_PM_TO    = 4'h1;
	localparam logic [3:0]  ADDR_BETAS    = 4'h2;
	localparam logic [3:0]  ADDR_FAST     = 4'h3;
	localparam logic [3:0]  ADDR_MAXCNT   = 4'h4;
	localparam logic [3:0]  ADDR_EVT_TO   = 4'h5;
	localparam logic [3:0]  ADDR_TUNE     = 4'h6;
	localparam logic [3:0]  ADDR_STATUS   = 4'h7;
	localparam logic [3:0]  ADDR_CH_BASE  = 4'h8;
	localparam logic [3:0]  ADDR_THR      = 4'hB;
	localparam logic [3:0]  ADDR_DEB      = 4'hC;
	localparam logic [3:0]  ADDR_TUNE_OUT = 4'hD;
	typedef enum logic [2:0] {
		pm_normal, pm_low, pm_ultra, pm_halt, pm_auto, pm_auto_no_ultra
	} pm_sel_type;
	typedef enum logic [1:0] {
		tm_full, tm_fine, tm_comp_div, tm_comp_only
	} tune_mode_type;
	typedef struct packed {
		logic        linearise;
		logic        invert;
		logic        dual_dir;
	} ch_cfg_type;
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;
endpackage : touch_pkg

/* rtl/touch_channel_processing.sv */
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module touch_channel_processing #(
	parameter int N_CH = touch_pkg::NUM_CH
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire touch_pkg::bus_req_type bus_req,
	output logic [31:0]              rd_data,
	input  wire logic [N_CH*touch_pkg::CW-1:0] raw_counts,
	input  wire logic [N_CH-1:0]     sample_valid,
	input  wire logic                tick,
	output logic [1:0]               cur_power_mode,
	output logic [N_CH-1:0]          channel_near_flag,
	output logic [N_CH-1:0]          channel_contact_flag
);
	import touch_pkg::*;

	// status packs three flags per kind, so more channels cannot be reported
	if (N_CH < 1 || N_CH > 3) begin : g_bad_ch
		$error("channel count not supported");
	end

	// configuration registers
	pm_sel_type        pm_sel_q;
	logic              reseed_q;
	logic [N_CH-1:0]   channel_timeout_disable_q;
	logic [7:0]        pm_timeout_q;
	logic [7:0]        beta_cnt_np_q, beta_cnt_lp_q, beta_lta_np_q, beta_lta_lp_q;
	logic [7:0]        beta_fast_q;
	logic [CW-1:0]     fast_band_q;
	logic [CW-1:0]     max_counts_q;
	logic [7:0]        near_timeout_q, contact_timeout_q;
	tune_mode_type     tune_mode_q;
	logic              tune_start_q;
	logic [CW-1:0]     tuning_base_value_q;
	logic [7:0]        tuning_resolution_factor_q;
	ch_cfg_type        ch_cfg_q [N_CH];
	logic [CW-1:0]     near_thr_q, contact_thr_q, contact_hyst_q;
	logic [3:0]        deb_enter_q, deb_exit_q;

	// channel state
	logic [CW-1:0]     filt_q [N_CH];
	logic [CW-1:0]     long_term_average_q [N_CH];
	logic [3:0]        deb_q [N_CH];
	logic [7:0]        evt_timer_q [N_CH];
	logic [N_CH-1:0]   reseed_ch;
	logic [N_CH-1:0]   near_cond, contact_cond, contact_hold;
	logic [7:0]        idle_q;
	logic              any_event;

	// tuning results
	logic [1:0]        tune_step_q;
	logic [7:0]        coarse_q, fine_q;
	logic [CW-1:0]     tune_target_q;
	logic              tune_busy_q;

	function automatic logic [CW-1:0] iir(input logic [CW-1:0] y, input logic [CW-1:0] x,
		input logic [7:0] beta);
		logic [CW+8:0] acc;
		// beta weights the old value, so a larger beta damps harder
		acc = {9'h000, y} * 25'({1'b0, beta}) + {9'h000, x} * 25'(9'h100 - {1'b0, beta});
		iir = acc[CW+BETA_SHIFT-1:BETA_SHIFT];
	endfunction : iir

	function automatic logic [CW-1:0] dev(input logic [CW-1:0] a, input logic [CW-1:0] b);
		dev = (a > b) ? a - b : '0;
	endfunction : dev

	wire np_mode = (cur_power_mode == 2'h0);

	// register writes
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pm_sel_q                   <= pm_normal;
			reseed_q                   <= 1'b0;
			channel_timeout_disable_q  <= '0;
			pm_timeout_q               <= 8'h00;
			beta_cnt_np_q              <= 8'h80;
			beta_cnt_lp_q              <= 8'h80;
			beta_lta_np_q              <= 8'hF8;
			beta_lta_lp_q              <= 8'hF8;
			beta_fast_q                <= 8'h40;
			fast_band_q                <= 16'h0040;
			max_counts_q               <= 16'hFFFF;
			near_timeout_q             <= 8'h00;
			contact_timeout_q          <= 8'h00;
			tune_mode_q                <= tm_full;
			tune_start_q               <= 1'b0;
			tuning_base_value_q        <= 16'h0200;
			tuning_resolution_factor_q <= 8'h10;
			near_thr_q                 <= 16'h0010;
			contact_thr_q              <= 16'h0030;
			contact_hyst_q             <= 16'h0008;
			deb_enter_q                <= 4'h2;
			deb_exit_q                 <= 4'h2;
			for (int i = 0; i < N_CH; i++) ch_cfg_q[i] <= '0;
		end else begin
			if (bus_req.wr) begin
				unique case (bus_req.addr)
				ADDR_SYS_CTRL: begin
					pm_sel_q <= pm_sel_type'(bus_req.wdata[2:0]);
					reseed_q <= bus_req.wdata[3] | reseed_q;
					channel_timeout_disable_q <= bus_req.wdata[4 +: N_CH];
					tune_start_q <= bus_req.wdata[8];
				end
				ADDR_PM_TO: pm_timeout_q <= bus_req.wdata[7:0];
				ADDR_BETAS: {beta_lta_lp_q, beta_lta_np_q, beta_cnt_lp_q, beta_cnt_np_q}
					<= bus_req.wdata;
				ADDR_FAST: {beta_fast_q, fast_band_q} <= bus_req.wdata[23:0];
				ADDR_MAXCNT: max_counts_q <= bus_req.wdata[CW-1:0];
				ADDR_EVT_TO: {contact_timeout_q, near_timeout_q} <= bus_req.wdata[15:0];
				ADDR_TUNE: begin
					tune_mode_q <= tune_mode_type'(bus_req.wdata[25:24]);
					tuning_resolution_factor_q <= bus_req.wdata[23:16];
					tuning_base_value_q <= bus_req.wdata[15:0];
				end
				ADDR_THR: begin
					near_thr_q     <= {6'h00, bus_req.wdata[9:0]};
					contact_thr_q  <= {6'h00, bus_req.wdata[19:10]};
					contact_hyst_q <= {6'h00, bus_req.wdata[29:20]};
				end
				ADDR_DEB: {deb_exit_q, deb_enter_q} <= bus_req.wdata[7:0];
				default: begin
					for (int i = 0; i < N_CH; i++)
						if (bus_req.addr == ADDR_CH_BASE + 4'(i))
							ch_cfg_q[i] <= bus_req.wdata[2:0];
				end
				endcase
			end
			// hardware clear; a new host set in the same cycle wins
			if (reseed_q && !(bus_req.wr && bus_req.addr == ADDR_SYS_CTRL
				&& bus_req.wdata[3]))
				reseed_q <= 1'b0;
			if (tune_busy_q && !(bus_req.wr && bus_req.addr == ADDR_SYS_CTRL
				&& bus_req.wdata[8]))
				tune_start_q <= 1'b0;
		end
	end

	// per channel detection
	for (genvar c = 0; c < N_CH; c++) begin : g_ch
		logic [CW-1:0] raw, lim, rep, cur, below, above, fwd, opp;
		logic [7:0]    beta_c, beta_l;
		assign raw = raw_counts[c*CW +: CW];
		assign lim = (raw > max_counts_q) ? max_counts_q : raw;
		// linearised as a simple inversion, done after limiting
		assign rep = ch_cfg_q[c].linearise ? ~lim : lim;
		// judge the sample being taken, not the one before it
		assign cur = iir(filt_q[c], rep, beta_c);
		assign below = dev(long_term_average_q[c], cur);
		assign above = dev(cur, long_term_average_q[c]);
		assign fwd = ch_cfg_q[c].invert ? above : below;
		assign opp = ch_cfg_q[c].invert ? below : above;
		assign near_cond[c] = ch_cfg_q[c].dual_dir ? (above > near_thr_q || below > near_thr_q)
			: (fwd > near_thr_q);
		assign contact_cond[c] = ch_cfg_q[c].dual_dir
			? (above > contact_thr_q || below > contact_thr_q) : (fwd > contact_thr_q);
		assign contact_hold[c] = fwd > dev(contact_thr_q, contact_hyst_q)
			|| (ch_cfg_q[c].dual_dir && opp > dev(contact_thr_q, contact_hyst_q));
		assign beta_c = np_mode ? beta_cnt_np_q : beta_cnt_lp_q;
		assign beta_l = (opp > fast_band_q) ? beta_fast_q
			: (np_mode ? beta_lta_np_q : beta_lta_lp_q);
		assign reseed_ch[c] = reseed_q || (!channel_timeout_disable_q[c] && (
			(channel_near_flag[c] && near_timeout_q != 8'h00 && evt_timer_q[c] >= near_timeout_q)
			|| (channel_contact_flag[c] && contact_timeout_q != 8'h00
			&& evt_timer_q[c] >= contact_timeout_q)));

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				filt_q[c]               <= CNT_RESET;
				long_term_average_q[c]  <= CNT_RESET;
			end else begin
				if (sample_valid[c]) filt_q[c] <= cur;
				// a reseed need not wait for a sample, so the bit clears in one cycle
				if (reseed_ch[c])
					long_term_average_q[c] <= filt_q[c];
				else if (sample_valid[c] && !channel_near_flag[c] && !channel_contact_flag[c])
					long_term_average_q[c] <= iir(long_term_average_q[c], filt_q[c], beta_l);
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				deb_q[c]                <= 4'h0;
				channel_near_flag[c]    <= 1'b0;
				channel_contact_flag[c] <= 1'b0;
			end else if (reseed_ch[c]) begin
				deb_q[c]                <= 4'h0;
				channel_near_flag[c]    <= 1'b0;
				channel_contact_flag[c] <= 1'b0;
			end else if (sample_valid[c]) begin
				if (near_cond[c] == channel_near_flag[c]) deb_q[c] <= 4'h0;
				else if (deb_q[c] >= (channel_near_flag[c] ? deb_exit_q : deb_enter_q)) begin
					channel_near_flag[c] <= near_cond[c];
					deb_q[c] <= 4'h0;
				end else deb_q[c] <= deb_q[c] + 4'h1;
				channel_contact_flag[c] <= channel_contact_flag[c] ? contact_hold[c]
					: contact_cond[c];
			end
		end

		// event timer counts ticks while near or contact is set, held at zero otherwise
		always_ff @(posedge ref_clk) begin
			if (!rst_b || !(channel_near_flag[c] || channel_contact_flag[c]))
				evt_timer_q[c] <= 8'h00;
			else if (tick && evt_timer_q[c] != 8'hFF)
				evt_timer_q[c] <= evt_timer_q[c] + 8'h01;
		end
	end

	assign any_event = |{channel_near_flag, channel_contact_flag};

	// power mode stepping; halt is left only by host write
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_power_mode <= 2'h0;
			idle_q         <= 8'h00;
		end else if (pm_sel_q == pm_auto || pm_sel_q == pm_auto_no_ultra) begin
			if (any_event) begin
				cur_power_mode <= 2'h0;
				idle_q         <= 8'h00;
			end else if (pm_timeout_q != TIMEOUT_NEVER && tick) begin
				if (idle_q + 8'h01 >= pm_timeout_q) begin
					idle_q <= 8'h00;
					if (cur_power_mode == 2'h0) cur_power_mode <= 2'h1;
					else if (cur_power_mode == 2'h1 && pm_sel_q == pm_auto)
						cur_power_mode <= 2'h2;
				end else idle_q <= idle_q + 8'h01;
			end
		end else begin
			idle_q <= 8'h00;
			unique case (pm_sel_q)
			pm_low:   cur_power_mode <= 2'h1;
			pm_ultra: cur_power_mode <= 2'h2;
			pm_halt:  cur_power_mode <= 2'h3;
			default:  cur_power_mode <= 2'h0;
			endcase
		end
	end

	// tuning sequence over channel 0 counts: coarse, fine, compensation
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tune_busy_q   <= 1'b0;
			tune_step_q   <= 2'h0;
			coarse_q      <= 8'h00;
			fine_q        <= 8'h00;
			tune_target_q <= CNT_RESET;
		end else if (!tune_busy_q) begin
			if (tune_start_q) begin
				tune_busy_q <= 1'b1;
				// both compensation modes enter at the compensation step
				tune_step_q <= (tune_mode_q == tm_comp_only) ? 2'h2 : 2'(tune_mode_q);
			end
		end else if (sample_valid[0]) begin
			unique case (tune_step_q)
			2'h0: begin
				coarse_q <= (filt_q[0] > tuning_base_value_q) ? coarse_q + 8'h10 : coarse_q;
				tune_step_q <= 2'h1;
			end
			2'h1: begin
				fine_q <= (filt_q[0] > tuning_base_value_q) ? fine_q + 8'h01 : fine_q - 8'h01;
				tune_step_q <= 2'h2;
			end
			2'h2: begin
				tune_target_q <= CW'(({8'h00, filt_q[0]} * {16'h0000, tuning_resolution_factor_q})
					>> RES_SHIFT);
				tune_step_q <= 2'h3;
			end
			2'h3: tune_busy_q <= 1'b0;
			endcase
		end
	end

	// register reads, data one cycle later
	always_ff @(posedge ref_clk) begin
		if (!rst_b) rd_data <= 32'h0000_0000;
		else if (bus_req.rd) begin
			rd_data <= 32'h0000_0000;
			unique case (bus_req.addr)
			ADDR_SYS_CTRL: rd_data <= {23'h0, tune_start_q, 1'b0,
				3'(channel_timeout_disable_q), reseed_q, pm_sel_q};
			ADDR_STATUS: rd_data <= {23'h0, tune_busy_q, 3'(channel_contact_flag),
				3'(channel_near_flag), cur_power_mode};
			ADDR_TUNE_OUT: rd_data <= {coarse_q, fine_q, tune_target_q};
			ADDR_PM_TO: rd_data <= {24'h0, pm_timeout_q};
			default: begin
				for (int i = 0; i < N_CH; i++)
					if (bus_req.addr == ADDR_CH_BASE + 4'(i))
						rd_data <= {long_term_average_q[i], filt_q[i]};
			end
			endcase
		end
	end

	near_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(channel_near_flag[0]) |-> $past(near_cond[0]))
		else $error("proximity set without condition");
	lta_frozen_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(channel_near_flag[0]) && !$past(reseed_ch[0]) |->
		$stable(long_term_average_q[0]))
		else $error("reference moved during event");
	reseed_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		reseed_q && !bus_req.wr |=> !reseed_q)
		else $error("reseed bit stuck");
	event_np_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		any_event && pm_sel_q == pm_auto |=> cur_power_mode == 2'h0)
		else $error("event did not return normal power");
	no_ultra_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pm_sel_q == pm_auto_no_ultra && cur_power_mode != 2'h2 |=> cur_power_mode != 2'h2)
		else $error("deepest mode entered");
	zero_to_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pm_sel_q == pm_auto && pm_timeout_q == 8'h00 && cur_power_mode == 2'h0
		|=> cur_power_mode == 2'h0)
		else $error("mode lowered with zero timeout");
	max_lim_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sample_valid[0] && !ch_cfg_q[0].linearise && g_ch[0].beta_c == 8'h00
		|=> filt_q[0] <= $past(max_counts_q))
		else $error("count above limit");
	timeout_dis_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		channel_timeout_disable_q[0] && !reseed_q && !sample_valid[0]
		|=> $stable(channel_near_flag[0]) && $stable(channel_contact_flag[0]))
		else $error("disabled timeout reseeded");
	near_cov: cover property (@(posedge ref_clk) $rose(channel_near_flag[0]));
	contact_cov: cover property (@(posedge ref_clk) $rose(channel_contact_flag[0]));
	step_cov: cover property (@(posedge ref_clk) $rose(cur_power_mode == 2'h1));
endmodule : touch_channel_processing

/* bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
	input  wire logic              ref_clk,
	output touch_pkg::bus_req_type bus_req,
	output logic                   rd_valid
);
	import touch_pkg::*;
	initial begin
		bus_req = '0;
	end
	// read data first stand in the cycle after the strobe and hold until the next read, so flag that cycle
	always_ff @(posedge ref_clk) begin
		rd_valid <= bus_req.rd;
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
	endtask : rd
	// host only sets the bit; clearing it is left to the block
	task automatic reseed(input logic [31:0] mode);
		wr(ADDR_SYS_CTRL, mode | 32'h0000_0008);
	endtask : reseed
	// the forced request is implied by the access itself in this model
	task automatic leave_halt(input logic [31:0] mode);
		wr(ADDR_SYS_CTRL, mode);
	endtask : leave_halt
endmodule : host_model

/* bench/touch_channel_processing_test.sv */
`timescale 1ns/1ps
module touch_channel_processing_test;
	import touch_pkg::*;
	typedef struct {
		string       nm;
		logic [31:0] v;
		logic [31:0] m;
	} note_type;
	logic                 ref_clk;
	logic                 rst_b;
	bus_req_type          bus_req;
	logic                 rd_valid;
	logic [31:0]          rd_data;
	logic [NUM_CH*CW-1:0] raw_counts;
	logic [NUM_CH-1:0]    sample_valid;
	logic                 tick;
	logic [1:0]           cur_power_mode;
	logic [NUM_CH-1:0]    near;
	logic [NUM_CH-1:0]    contact;
	note_type             notes[$];
	note_type             n;
	int                   err_total;
	int                   cmp_count;
	int                   seed;
	logic [31:0]          r;
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	host_model host (
		.ref_clk  (ref_clk),
		.bus_req  (bus_req),
		.rd_valid (rd_valid)
	);
	touch_channel_processing uut (
		.ref_clk              (ref_clk),
		.rst_b                (rst_b),
		.bus_req              (bus_req),
		.rd_data              (rd_data),
		.raw_counts           (raw_counts),
		.sample_valid         (sample_valid),
		.tick                 (tick),
		.cur_power_mode       (cur_power_mode),
		.channel_near_flag    (near),
		.channel_contact_flag (contact)
	);
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] v,
			input logic [31:0] m);
		notes.push_back('{nm, v, m});
		host.rd(a);
	endtask : rd
	// the watcher pairs each read answer with the oldest note
	always @(negedge ref_clk) begin
		if (rd_valid === 1'b1) begin
			n = notes.pop_front();
			chk(n.nm, n.v, rd_data & n.m);
		end
	end
	task automatic smp(input int c, input logic [15:0] v);
		@(posedge ref_clk);
		raw_counts[c*CW+:CW] <= v;
		sample_valid[c] <= 1'b1;
		@(posedge ref_clk);
		sample_valid <= '0;
		@(negedge ref_clk);
	endtask : smp
	task automatic tk(input int k);
		repeat (k) begin
			@(posedge ref_clk);
			tick <= 1'b1;
			@(posedge ref_clk);
			tick <= 1'b0;
			@(negedge ref_clk);
		end
	endtask : tk
	task automatic wait_mode(input logic [1:0] m, input int lim);
		int i;
		for (i = 0; i < lim && cur_power_mode !== m; i++) begin
			tk(1);
		end
		chk("power mode", 32'(m), 32'(cur_power_mode));
	endtask : wait_mode
	task automatic print_verdict();
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (100000) @(posedge ref_clk);
		err_total++;
		$display("[FAIL] run length expected finish seen timeout");
		print_verdict();
	end
	initial begin
		int i;
		seed = 19232;
		err_total = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		tick = 1'b0;
		sample_valid = '0;
		raw_counts = '0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd("status", ADDR_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		rd("unmapped", 4'hE, 32'h0000_0000, 32'hFFFF_FFFF);
		host.wr(4'hF, 32'hFFFF_FFFF);
		rd("unmapped", 4'hF, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("test reset done");
		host.wr(ADDR_SYS_CTRL, 32'(pm_halt));
		wait_mode(2'h3, 4);
		host.leave_halt(32'(pm_normal));
		wait_mode(2'h0, 4);
		host.wr(ADDR_PM_TO, 32'h0000_0000);
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto));
		tk(6);
		chk("zero timeout mode", 32'h0, 32'(cur_power_mode));
		host.wr(ADDR_PM_TO, 32'h0000_0002);
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto_no_ultra));
		wait_mode(2'h1, 8);
		tk(8);
		chk("no deepest mode", 32'h1, 32'(cur_power_mode));
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto));
		wait_mode(2'h2, 8);
		$display("test power modes done");
		// beta 0 passes counts straight through, so the limit shows unsmoothed
		host.wr(ADDR_BETAS, 32'hFFFF_0000);
		host.wr(ADDR_FAST, 32'h00FF_FFFF);
		host.wr(ADDR_MAXCNT, 32'h0000_0100);
		r = $random(seed);
		smp(0, 16'h0101 + 16'(r[15:0] % 16'hFEFF));
		rd("max limit", ADDR_CH_BASE, 32'h0000_0100, 32'h0000_FFFF);
		host.wr(ADDR_CH_BASE, 32'h0000_0006);
		r = $random(seed);
		smp(0, 16'h0101 + 16'(r[15:0] % 16'hFEFF));
		rd("linearised", ADDR_CH_BASE, 32'h0000_FEFF, 32'h0000_FFFF);
		host.wr(ADDR_CH_BASE, 32'h0000_0000);
		host.wr(ADDR_MAXCNT, 32'h0000_FFFF);
		$display("test count limit done");
		host.wr(ADDR_THR, {2'h0, 10'd10, 10'd50, 10'd20});
		host.wr(ADDR_DEB, 32'h0000_0022);
		smp(0, 16'd1000);
		host.reseed(32'(pm_auto));
		rd("reseed bit", ADDR_SYS_CTRL, 32'h0000_0004, 32'h0000_000F);
		rd("seeded ref", ADDR_CH_BASE, {16'd1000, 16'h0}, 32'hFFFF_0000);
		tk(4);
		chk("stepped down", 32'h2, 32'(cur_power_mode));
		smp(0, 16'd970);
		smp(0, 16'd970);
		chk("near early", 32'h0, 32'(near[0]));
		smp(0, 16'd970);
		chk("near entered", 32'h1, 32'(near[0]));
		smp(0, 16'd940);
		chk("contact entered", 32'h1, 32'(contact[0]));
		chk("event wake", 32'h0, 32'(cur_power_mode));
		smp(0, 16'd955);
		chk("contact held", 32'h1, 32'(contact[0]));
		smp(0, 16'd965);
		chk("contact left", 32'h0, 32'(contact[0]));
		smp(0, 16'd1000);
		smp(0, 16'd1000);
		chk("near held", 32'h1, 32'(near[0]));
		smp(0, 16'd1000);
		chk("near left", 32'h0, 32'(near[0]));
		$display("test thresholds done");
		for (i = 0; i < 3; i++) begin
			smp(0, 16'd970);
		end
		host.wr(ADDR_EVT_TO, 32'h0000_0003);
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto) | 32'h0000_0010);
		tk(6);
		chk("timeout disabled", 32'h1, 32'(near[0]));
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto));
		for (i = 0; i < 8 && near[0] !== 1'b0; i++) begin
			tk(1);
		end
		chk("timeout reseed", 32'h0, 32'(near[0]));
		$display("test event timeout done");
		// compensation only: dividers stay put, target is counts times factor over 16
		host.wr(ADDR_TUNE, 32'h0320_0200);
		host.wr(ADDR_SYS_CTRL, 32'(pm_auto) | 32'h0000_0100);
		smp(0, 16'd500);
		smp(0, 16'd500);
		rd("tuning target", ADDR_TUNE_OUT, 32'h0000_0794, 32'hFFFF_FFFF);
		// beta 0xC0 keeps three quarters of the old value
		host.wr(ADDR_BETAS, 32'hFFFF_C0C0);
		smp(0, 16'd100);
		rd("iir beta", ADDR_CH_BASE, 32'h0000_0190, 32'h0000_FFFF);
		$display("test tuning and filter done");
		print_verdict();
	end
endmodule : touch_channel_processing_test
